// ===== verilog/rev_regs_top.sv
// rev_regs_top: channel enable and voltage code register bank with its
// link-side access port, pin synchronisers and voltage scaling.
// assumes a bus engine on the link clock issuing one request at a time,
// static fuse code inputs, and nrst_i being the internal power-on reset.
//
// Function
// RULE1: channel runs when software bit and pin high
// RULE2: software enable bits reset to one
// RULE3: enable bits written only while pin high
// RULE4: pin low forces enable bit to one
// RULE5: enable register holds five bits, reserved stored
// RULE6: channel 1 code in low five bits
// RULE7: code fields reset from fuse values
// RULE8: channel 3 code in bits six to four
// RULE9: channel 2 code in low three bits
// RULE10: channel 4 code in low five bits
// RULE11: bit six enables channel 4 scaling
// RULE12: bits five four pick channel 4 interval
// RULE13: bit two enables channel 1 scaling
// RULE14: bits one zero pick channel 1 interval
// RULE15: reset values load only during power-on reset
// RULE16: codes map linearly, fields read back unchanged; channel 4 maps piecewise, channel 2 code 7 gives 5000 mV
// RULE17: reserved bits stored, read back, no effect
`timescale 1ns/100ps
`default_nettype none
module rev_regs_top
  import rev_pkg::*;
#(
  parameter int STEP_CYC0 = rev_pkg::STEP_T0_CYC,
  parameter int STEP_CYC1 = rev_pkg::STEP_T1_CYC
) (
  input  wire logic                               clk_i,
  input  wire logic                               nrst_i,
  input  wire logic                               ce_i,
  input  wire logic [rev_pkg::NUM_CH-1:0]         chan_hw_enable_pin_i,
  input  wire logic [rev_pkg::CH1_CODE_W-1:0]     fuse_ch1_code_i,
  input  wire logic [rev_pkg::CH2_CODE_W-1:0]     fuse_ch2_code_i,
  input  wire logic [rev_pkg::CH3_CODE_W-1:0]     fuse_ch3_code_i,
  input  wire logic [rev_pkg::CH4_CODE_W-1:0]     fuse_ch4_code_i,
  input  wire logic                               lnk_clk_i,
  input  wire logic                               lnk_req_i,
  input  wire logic                               lnk_we_i,
  input  wire logic [rev_pkg::AW-1:0]             lnk_addr_i,
  input  wire logic [rev_pkg::DW-1:0]             lnk_wdata_i,
  output logic                                    lnk_busy_o,
  output logic                                    lnk_done_o,
  output logic      [rev_pkg::DW-1:0]             lnk_rdata_o,
  output logic      [rev_pkg::NUM_CH-1:0]         chan_run_o,
  output logic      [rev_pkg::CH1_CODE_W-1:0]     ch1_code_o,
  output logic      [rev_pkg::CH2_CODE_W-1:0]     ch2_code_o,
  output logic      [rev_pkg::CH3_CODE_W-1:0]     ch3_code_o,
  output logic      [rev_pkg::CH4_CODE_W-1:0]     ch4_code_o,
  output logic      [rev_pkg::MV_W-1:0]           ch1_mv_o,
  output logic      [rev_pkg::MV_W-1:0]           ch2_mv_o,
  output logic      [rev_pkg::MV_W-1:0]           ch3_mv_o,
  output logic      [rev_pkg::MV_W-1:0]           ch4_mv_o
);

  // link-domain state
  typedef struct packed {
    logic          tog;
    logic          ack_s1;
    logic          ack_s2;
    logic          ack_s3;
    logic          we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    logic          done;
  } rev_lnk_st_t;

  // core-domain state
  typedef struct packed {
    logic              req_seen;
    logic              ack_tog;
    logic [DW-1:0]     resp;
    logic [DW-1:0]     enable_ctrl;
    logic [DW-1:0]     ch1_voltage_code;
    logic [DW-1:0]     ch2_ch3_voltage_code;
    logic [DW-1:0]     ch4_voltage_code;
    logic [DW-1:0]     scale_cfg;
    logic [NUM_CH-1:0] run;
    logic [MV_W-1:0]   mv1;
    logic [MV_W-1:0]   mv2;
    logic [MV_W-1:0]   mv3;
    logic [MV_W-1:0]   mv4;
  } rev_core_st_t;

  rev_lnk_st_t       l_r;
  rev_lnk_st_t       l_nxt;
  rev_core_st_t      c_r;
  rev_core_st_t      c_nxt;
  logic              lrst_s1_n;
  logic              lrst_s2_n;
  logic [NUM_CH-1:0] pin_s;
  logic              req_tog_s;
  logic              req_new;
  logic              wr_en;

  rev_ramp_if #(.W(CH1_CODE_W)) ch1_rif ();
  rev_ramp_if #(.W(CH4_CODE_W)) ch4_rif ();

  // code to millivolt conversions
  function automatic logic [MV_W-1:0] ch1_mv(input logic [CH1_CODE_W-1:0] c);
    if (c == '0) begin
      ch1_mv = MV_W'(ADJ_MV);
    end else begin
      ch1_mv = MV_W'(825 + 25 * int'(c)); // see RULE16
    end
  endfunction

  function automatic logic [MV_W-1:0] ch2_mv(input logic [CH2_CODE_W-1:0] c);
    if (c == '0) begin
      ch2_mv = MV_W'(ADJ_MV);
    end else if (c == '1) begin
      ch2_mv = MV_W'(5000);
    end else begin
      ch2_mv = MV_W'(3000 + 300 * int'(c));
    end
  endfunction

  function automatic logic [MV_W-1:0] ch3_mv(input logic [CH3_CODE_W-1:0] c);
    if (c == '0) begin
      ch3_mv = MV_W'(ADJ_MV);
    end else begin
      ch3_mv = MV_W'(1100 + 100 * int'(c));
    end
  endfunction

  // the channel 4 table is not uniform; interpolate between given points
  function automatic logic [MV_W-1:0] ch4_mv(input logic [CH4_CODE_W-1:0] c);
    int v;
    v = int'(c);
    if (v == 0) begin
      ch4_mv = MV_W'(ADJ_MV);
    end else if (v <= 6) begin
      ch4_mv = MV_W'(2400 + 100 * v); // see RULE16
    end else if (v <= 24) begin
      ch4_mv = MV_W'(3000 + ((v - 6) * 1000) / 18);
    end else if (v <= 30) begin
      ch4_mv = MV_W'(4000 + ((v - 24) * 1400) / 6);
    end else begin
      ch4_mv = MV_W'(5500);
    end
  endfunction

  function automatic logic [DW-1:0] read_reg(input logic [AW-1:0] a, input rev_core_st_t s);
    case (a)
      ADDR_ENABLE: read_reg = s.enable_ctrl; // see RULE17
      ADDR_CH1_VOLTAGE_CODE:   read_reg = s.ch1_voltage_code;
      ADDR_CH2_CH3_VOLTAGE_CODE:  read_reg = s.ch2_ch3_voltage_code;
      ADDR_CH4_VOLTAGE_CODE:   read_reg = s.ch4_voltage_code;
      ADDR_SCALE:  read_reg = s.scale_cfg;
      default:     read_reg = UNMAPPED_RD;
    endcase
  endfunction

  // link reset follows the core reset through a two-flop chain
  always_ff @(posedge lnk_clk_i) begin
    lrst_s1_n <= nrst_i;
    lrst_s2_n <= lrst_s1_n;
  end

  // link side: hold the request, toggle, wait for the returned toggle
  always_comb begin
    l_nxt        = l_r;
    l_nxt.ack_s1 = c_r.ack_tog;
    l_nxt.ack_s2 = l_r.ack_s1;
    l_nxt.ack_s3 = l_r.ack_s2;
    l_nxt.done   = 1'b0;
    if (lnk_req_i && (l_r.tog == l_r.ack_s2)) begin
      l_nxt.tog   = ~l_r.tog;
      l_nxt.we    = lnk_we_i;
      l_nxt.addr  = lnk_addr_i;
      l_nxt.wdata = lnk_wdata_i;
    end
    if (l_r.ack_s2 != l_r.ack_s3) begin
      // core holds resp steady until the next request, so capture is safe
      l_nxt.rdata = c_r.resp;
      l_nxt.done  = 1'b1;
    end
  end

  always_ff @(posedge lnk_clk_i) begin
    if (!lrst_s2_n) begin
      l_r <= '0;
    end else begin
      l_r <= l_nxt;
    end
  end

  assign lnk_busy_o  = l_r.tog != l_r.ack_s2;
  assign lnk_done_o  = l_r.done;
  assign lnk_rdata_o = l_r.rdata;

  rev_sync #(.W(NUM_CH)) u_pin_sync (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .ce_i   (ce_i),
    .d_i    (chan_hw_enable_pin_i),
    .q_o    (pin_s)
  );

  rev_sync #(.W(1)) u_req_sync (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .ce_i   (ce_i),
    .d_i    (l_r.tog),
    .q_o    (req_tog_s)
  );

  assign req_new = req_tog_s != c_r.req_seen;
  // link addr, data and we are stable while its toggle is outstanding
  assign wr_en   = req_new && l_r.we;

  // core side: register file, enable gating and code conversion
  always_comb begin
    c_nxt = c_r;
    if (req_new) begin
      c_nxt.req_seen = req_tog_s;
      c_nxt.ack_tog  = ~c_r.ack_tog;
      c_nxt.resp     = read_reg(l_r.addr, c_r);
    end
    if (wr_en) begin
      case (l_r.addr)
        ADDR_ENABLE: begin
          // reserved bits take any write
          c_nxt.enable_ctrl[DW-1:NUM_CH] = l_r.wdata[DW-1:NUM_CH]; // see RULE5
        end
        ADDR_CH1_VOLTAGE_CODE:  c_nxt.ch1_voltage_code      = l_r.wdata; // see RULE6
        ADDR_CH2_CH3_VOLTAGE_CODE: c_nxt.ch2_ch3_voltage_code     = l_r.wdata; // see RULE8, see RULE9
        ADDR_CH4_VOLTAGE_CODE:  c_nxt.ch4_voltage_code      = l_r.wdata; // see RULE10
        ADDR_SCALE: c_nxt.scale_cfg = l_r.wdata; // see RULE11, see RULE13
        default: begin
        end
      endcase
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (!pin_s[i]) begin
        // pin low wins over any write so the next startup is clean
        c_nxt.enable_ctrl[i] = 1'b1; // see RULE4
      end else if (wr_en && (l_r.addr == ADDR_ENABLE)) begin
        c_nxt.enable_ctrl[i] = l_r.wdata[i]; // see RULE3
      end
    end
    c_nxt.run = c_r.enable_ctrl[NUM_CH-1:0] & pin_s; // see RULE1
    c_nxt.mv1 = ch1_mv(ch1_rif.cur);
    c_nxt.mv2 = ch2_mv(c_r.ch2_ch3_voltage_code[CH2_CODE_LSB +: CH2_CODE_W]);
    c_nxt.mv3 = ch3_mv(c_r.ch2_ch3_voltage_code[CH3_CODE_LSB +: CH3_CODE_W]);
    c_nxt.mv4 = ch4_mv(ch4_rif.cur);
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      // values load only while the power-on reset is held, see RULE15
      c_r             <= '0;
      c_r.enable_ctrl <= ENABLE_RST; // see RULE2
      c_r.ch1_voltage_code        <= {RSVD_RST[DW-1:CH1_CODE_W], fuse_ch1_code_i}; // see RULE7
      c_r.ch2_ch3_voltage_code       <= {RSVD_RST[0], fuse_ch3_code_i, RSVD_RST[0], fuse_ch2_code_i};
      c_r.ch4_voltage_code        <= {RSVD_RST[DW-1:CH4_CODE_W], fuse_ch4_code_i};
      c_r.scale_cfg   <= SCALE_RST; // see RULE11, see RULE13
    end else if (ce_i) begin
      c_r <= c_nxt;
    end
  end

  assign ch1_rif.target = c_r.ch1_voltage_code[CH1_CODE_LSB +: CH1_CODE_W];
  assign ch1_rif.init   = fuse_ch1_code_i;
  assign ch1_rif.en     = c_r.scale_cfg[CH1_SCALE_EN_BIT]; // see RULE13
  assign ch1_rif.sel    = c_r.scale_cfg[CH1_SCALE_SEL_LSB +: SEL_W]; // see RULE14
  assign ch4_rif.target = c_r.ch4_voltage_code[CH4_CODE_LSB +: CH4_CODE_W];
  assign ch4_rif.init   = fuse_ch4_code_i;
  assign ch4_rif.en     = c_r.scale_cfg[CH4_SCALE_EN_BIT]; // see RULE11
  assign ch4_rif.sel    = c_r.scale_cfg[CH4_SCALE_SEL_LSB +: SEL_W]; // see RULE12

  rev_ramp #(
    .W    (CH1_CODE_W),
    .CNT0 (STEP_CYC0),
    .CNT1 (STEP_CYC1),
    .CNT2 (STEP_T2_CYC),
    .CNT3 (STEP_T3_CYC)
  ) u_ch1_ramp (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .ce_i   (ce_i),
    .rif    (ch1_rif)
  );

  rev_ramp #(
    .W    (CH4_CODE_W),
    .CNT0 (STEP_CYC0),
    .CNT1 (STEP_CYC1),
    .CNT2 (STEP_T2_CYC),
    .CNT3 (STEP_T3_CYC)
  ) u_ch4_ramp (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .ce_i   (ce_i),
    .rif    (ch4_rif)
  );

  assign chan_run_o = c_r.run;
  assign ch1_code_o = ch1_rif.cur;
  assign ch2_code_o = c_r.ch2_ch3_voltage_code[CH2_CODE_LSB +: CH2_CODE_W];
  assign ch3_code_o = c_r.ch2_ch3_voltage_code[CH3_CODE_LSB +: CH3_CODE_W];
  assign ch4_code_o = ch4_rif.cur;
  assign ch1_mv_o   = c_r.mv1;
  assign ch2_mv_o   = c_r.mv2;
  assign ch3_mv_o   = c_r.mv3;
  assign ch4_mv_o   = c_r.mv4;

endmodule
`default_nettype wire

// ===== pkg/rev_pkg.sv
// rev_pkg: register map, field layout, reset values and timing counts
// of the regulator enable / voltage code register bank.
// assumes a 250 MHz core clock; all registers are 8 bits wide.
package rev_pkg;

  localparam int NUM_CH = 5;
  localparam int DW     = 8;
  localparam int AW     = 8;
  localparam int MV_W   = 13;

  // register offsets
  localparam logic [AW-1:0] ADDR_ENABLE = 8'h01;
  localparam logic [AW-1:0] ADDR_CH1_VOLTAGE_CODE   = 8'h02;
  localparam logic [AW-1:0] ADDR_CH2_CH3_VOLTAGE_CODE  = 8'h03;
  localparam logic [AW-1:0] ADDR_CH4_VOLTAGE_CODE   = 8'h04;
  localparam logic [AW-1:0] ADDR_SCALE  = 8'h05;

  // field positions and widths
  localparam int CH1_CODE_LSB = 0;
  localparam int CH1_CODE_W   = 5;
  localparam int CH2_CODE_LSB = 0;
  localparam int CH2_CODE_W   = 3;
  localparam int CH3_CODE_LSB = 4;
  localparam int CH3_CODE_W   = 3;
  localparam int CH4_CODE_LSB = 0;
  localparam int CH4_CODE_W   = 5;
  localparam int CH4_SCALE_EN_BIT  = 6;
  localparam int CH4_SCALE_SEL_LSB = 4;
  localparam int CH1_SCALE_EN_BIT  = 2;
  localparam int CH1_SCALE_SEL_LSB = 0;
  localparam int SEL_W = 2;

  // reset values (code fields come from the fuse inputs)
  localparam logic [DW-1:0] ENABLE_RST = 8'h1F;
  localparam logic [DW-1:0] SCALE_RST  = 8'h00;
  localparam logic [DW-1:0] RSVD_RST   = 8'h00;
  localparam logic [DW-1:0] UNMAPPED_RD = 8'h00;

  // adjustable-mode output code voltage in mV
  localparam int ADJ_MV = 800;

  // scaling step intervals, in ns, and their cycle counts
  localparam int CLK_MHZ      = 250;
  localparam int STEP_T0_NS   = 62500;
  localparam int STEP_T1_NS   = 31200;
  localparam int STEP_T2_NS   = 15600;
  localparam int STEP_T3_NS   = 7800;
  localparam int STEP_T0_CYC  = STEP_T0_NS * CLK_MHZ / 1000;
  localparam int STEP_T1_CYC  = STEP_T1_NS * CLK_MHZ / 1000;
  localparam int STEP_T2_CYC  = STEP_T2_NS * CLK_MHZ / 1000;
  localparam int STEP_T3_CYC  = STEP_T3_NS * CLK_MHZ / 1000;

endpackage

// ===== pkg/rev_ramp_if.sv
// rev_ramp_if: carries one channel's target code and scaling setup to
// its step generator and the ramped code back.
// assumes both ends sit on the core clock.
`timescale 1ns/100ps
`default_nettype none
interface rev_ramp_if #(
  parameter int W = 5
);
  logic [W-1:0] target;
  logic [W-1:0] init;
  logic [W-1:0] cur;
  logic         en;
  logic [1:0]   sel;

  modport ctrl (output target, output init, output en, output sel, input cur);
  modport ramp (input target, input init, input en, input sel, output cur);
endinterface
`default_nettype wire

// ===== verilog/rev_sync.sv
// rev_sync: two-flop synchroniser for a vector of independent levels.
// assumes each bit is a slow level; multi-bit words must not use it.
`timescale 1ns/100ps
`default_nettype none
module rev_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } rev_sync_st_t;

  rev_sync_st_t s_r;
  rev_sync_st_t s_nxt;

  always_comb begin
    s_nxt    = s_r;
    s_nxt.s1 = d_i;
    // first stage feeds the second stage only
    s_nxt.s2 = s_r.s1;
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s_r <= '0;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  assign q_o = s_r.s2;
endmodule
`default_nettype wire

// ===== verilog/rev_ramp.sv
// rev_ramp: moves a channel's applied code one step toward its target
// per scaling interval while scaling is on, else follows it at once.
// assumes target and setup come from core-clock registers.
`timescale 1ns/100ps
`default_nettype none
module rev_ramp
  import rev_pkg::*;
#(
  parameter int W    = 5,
  parameter int CNT0 = rev_pkg::STEP_T0_CYC,
  parameter int CNT1 = rev_pkg::STEP_T1_CYC,
  parameter int CNT2 = rev_pkg::STEP_T2_CYC,
  parameter int CNT3 = rev_pkg::STEP_T3_CYC
) (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic ce_i,
  rev_ramp_if.ramp  rif
);
  // counter sized for the longest interval, whichever select holds it
  localparam int CM01 = (CNT0 > CNT1) ? CNT0 : CNT1;
  localparam int CM23 = (CNT2 > CNT3) ? CNT2 : CNT3;
  localparam int CW   = $clog2(((CM01 > CM23) ? CM01 : CM23) + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic [W-1:0]  cur;
  } rev_ramp_st_t;

  rev_ramp_st_t s_r;
  rev_ramp_st_t s_nxt;

  function automatic logic [CW-1:0] step_limit(input logic [1:0] sel);
    case (sel)
      2'h0:    step_limit = CW'(CNT0 - 1);
      2'h1:    step_limit = CW'(CNT1 - 1);
      2'h2:    step_limit = CW'(CNT2 - 1);
      default: step_limit = CW'(CNT3 - 1);
    endcase
  endfunction

  always_comb begin
    s_nxt = s_r;
    if (!rif.en) begin
      s_nxt.cur = rif.target;
      s_nxt.cnt = '0;
    end else if (s_r.cur == rif.target) begin
      s_nxt.cnt = '0;
    end else if (s_r.cnt >= step_limit(rif.sel)) begin
      // one code per interval limits the output slew
      s_nxt.cnt = '0;
      if (s_r.cur < rif.target) begin
        s_nxt.cur = s_r.cur + W'(1);
      end else begin
        s_nxt.cur = s_r.cur - W'(1);
      end
    end else begin
      s_nxt.cnt = s_r.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s_r.cnt <= '0;
      s_r.cur <= rif.init;
    end else if (ce_i) begin
      s_r <= s_nxt;
    end
  end

  assign rif.cur = s_r.cur;
endmodule
`default_nettype wire

// ===== dv/rev_regs_chk.sv
// rev_regs_chk: port-level checks of the register bank.
// assumes binding into rev_regs_top, bench counts on the link port.
`timescale 1ns/100ps
`default_nettype none
module rev_regs_chk
  import rev_pkg::*;
(
  input wire logic                           clk_i,
  input wire logic                           nrst_i,
  input wire logic                           ce_i,
  input wire logic [rev_pkg::NUM_CH-1:0]     chan_hw_enable_pin_i,
  input wire logic [rev_pkg::CH1_CODE_W-1:0] fuse_ch1_code_i,
  input wire logic [rev_pkg::CH2_CODE_W-1:0] fuse_ch2_code_i,
  input wire logic [rev_pkg::CH3_CODE_W-1:0] fuse_ch3_code_i,
  input wire logic                           lnk_clk_i,
  input wire logic                           lnk_req_i,
  input wire logic                           lnk_busy_o,
  input wire logic                           lnk_done_o,
  input wire logic [rev_pkg::NUM_CH-1:0]     chan_run_o,
  input wire logic [rev_pkg::CH1_CODE_W-1:0] ch1_code_o,
  input wire logic [rev_pkg::CH2_CODE_W-1:0] ch2_code_o,
  input wire logic [rev_pkg::CH3_CODE_W-1:0] ch3_code_o,
  input wire logic [rev_pkg::MV_W-1:0]       ch1_mv_o,
  input wire logic [rev_pkg::MV_W-1:0]       ch2_mv_o,
  input wire logic [rev_pkg::MV_W-1:0]       ch3_mv_o
);
  // pins take two sync flops plus the run register, hence depth 3
  run_pin_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i [*4] |-> (chan_run_o & ~$past(chan_hw_enable_pin_i, 3)) == 5'h00)
    else $error("channel runs without its pin");
  pin_force_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (ce_i && !chan_hw_enable_pin_i[3]) [*4] ##1
    (ce_i && !lnk_busy_o && chan_hw_enable_pin_i[3]) [*5] |-> chan_run_o[3])
    else $error("channel 4 not restarted after pin low");
  fuse_rst_a: assert property (@(posedge clk_i)
    (!nrst_i && ce_i) [*2] |-> ch1_code_o == fuse_ch1_code_i &&
    ch2_code_o == fuse_ch2_code_i && ch3_code_o == fuse_ch3_code_i)
    else $error("code not loaded from fuse in reset");
  mv1_map_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i |=> ch1_mv_o == (($past(ch1_code_o) == 5'h00) ? 13'h320 :
      13'h339 + 13'h19 * $past(ch1_code_o)))
    else $error("channel 1 millivolt mismatch");
  mv2_map_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i |=> ch2_mv_o == (($past(ch2_code_o) == 3'h0) ? 13'h320 :
      ($past(ch2_code_o) == 3'h7) ? 13'h1388 : 13'hBB8 + 13'h12C * $past(ch2_code_o)))
    else $error("channel 2 millivolt mismatch");
  mv3_map_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ce_i |=> ch3_mv_o == (($past(ch3_code_o) == 3'h0) ? 13'h320 :
      13'h44C + 13'h64 * $past(ch3_code_o)))
    else $error("channel 3 millivolt mismatch");
  busy_take_a: assert property (@(posedge lnk_clk_i) disable iff (!nrst_i)
    lnk_req_i && !lnk_busy_o |=> lnk_busy_o)
    else $error("request not taken");
  done_bound_a: assert property (@(posedge lnk_clk_i) disable iff (!nrst_i)
    lnk_req_i && !lnk_busy_o |-> ##[4:10] lnk_done_o)
    else $error("request not answered in time");
  done_pulse_a: assert property (@(posedge lnk_clk_i) disable iff (!nrst_i)
    lnk_done_o |=> !lnk_done_o)
    else $error("done longer than one cycle");
  done_c: cover property (@(posedge lnk_clk_i) lnk_done_o);
  ramp_c: cover property (@(posedge clk_i) nrst_i && ch1_code_o != $past(ch1_code_o));
  run_c: cover property (@(posedge clk_i) chan_run_o == 5'h08);
endmodule
bind rev_regs_top rev_regs_chk rev_regs_chk_i (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
  .chan_hw_enable_pin_i(chan_hw_enable_pin_i), .fuse_ch1_code_i(fuse_ch1_code_i),
  .fuse_ch2_code_i(fuse_ch2_code_i), .fuse_ch3_code_i(fuse_ch3_code_i),
  .lnk_clk_i(lnk_clk_i), .lnk_req_i(lnk_req_i), .lnk_busy_o(lnk_busy_o),
  .lnk_done_o(lnk_done_o), .chan_run_o(chan_run_o), .ch1_code_o(ch1_code_o),
  .ch2_code_o(ch2_code_o), .ch3_code_o(ch3_code_o), .ch1_mv_o(ch1_mv_o),
  .ch2_mv_o(ch2_mv_o), .ch3_mv_o(ch3_mv_o));
`default_nettype wire

// ===== dv/rev_host_model.sv
// rev_host_model: bus engine side of the link port, one transfer at a time.
// assumes the link clock runs during and after reset.
`timescale 1ns/100ps
`default_nettype none
module rev_host_model
  import rev_pkg::*;
(
  input  wire logic                   lnk_clk_i,
  input  wire logic                   lnk_busy_i,
  input  wire logic                   lnk_done_i,
  input  wire logic [rev_pkg::DW-1:0] lnk_rdata_i,
  output var  logic                   lnk_req_o,
  output var  logic                   lnk_we_o,
  output var  logic [rev_pkg::AW-1:0] lnk_addr_o,
  output var  logic [rev_pkg::DW-1:0] lnk_wdata_o
);
  initial begin
    lnk_req_o = 1'b0;
    lnk_we_o = 1'b0;
    lnk_addr_o = 8'h00;
    lnk_wdata_o = 8'h00;
  end
  // gap idles a slow host; q stays unknown if no answer comes
  task automatic xfer(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d,
                      input int gap, output logic [DW-1:0] q);
    int n;
    q = 'x;
    while (lnk_busy_i !== 1'b0) @(posedge lnk_clk_i);
    repeat (gap + 1) @(posedge lnk_clk_i);
    lnk_req_o <= 1'b1;
    lnk_we_o <= w;
    lnk_addr_o <= a;
    lnk_wdata_o <= d;
    // raised while idle, so the very next edge takes it
    @(posedge lnk_clk_i);
    // released lines show the inverse so stale values cannot pass
    lnk_req_o <= 1'b0;
    lnk_we_o <= ~w;
    lnk_addr_o <= ~a;
    lnk_wdata_o <= ~d;
    // done stands a whole link cycle, so look mid-cycle to avoid edge races
    for (n = 0; n < 12 && lnk_done_i !== 1'b1; n++) @(negedge lnk_clk_i);
    if (lnk_done_i === 1'b1) q = lnk_rdata_i;
  endtask
endmodule
`default_nettype wire

// ===== dv/tb_rev_regs_top.sv
// tb_rev_regs_top: register, pin and scaling tests of the register bank.
// assumes the host model is the only master of the link port.
`timescale 1ns/100ps
`default_nettype none
module tb_rev_regs_top;
  import rev_pkg::*;
  logic            clk_i = 1'b0;
  logic            lnk_clk_i = 1'b0;
  logic            nrst_i = 1'b0;
  logic            ce = 1'b1;
  logic [4:0]      pins = 5'h1F;
  logic            req, we, busy, done;
  logic [7:0]      addr, wdata, rdata, q;
  logic [4:0]      run, c1, c4;
  logic [2:0]      c2, c3;
  logic [12:0]     mv1, mv2, mv3, mv4;
  int              fails = 0;
  int              comparisons = 0;
  logic [7:0]      ta [13] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h04, 8'h04, 8'h04,
                               8'h04, 8'h04, 8'h03, 8'h03, 8'h03};
  logic [7:0]      td [13] = '{8'h00, 8'h01, 8'h1F, 8'h1E, 8'hE3, 8'h00, 8'h01, 8'h06,
                               8'h18, 8'h1F, 8'h10, 8'h97, 8'h71};
  logic [12:0]     te [13] = '{13'h320, 13'h352, 13'h640, 13'h627, 13'h384, 13'h320,
                               13'h9C4, 13'hBB8, 13'hFA0, 13'h157C, 13'h320, 13'h1388,
                               13'hCE4};
  always #2 clk_i = ~clk_i;
  initial begin
    #1.3;
    forever #3 lnk_clk_i = ~lnk_clk_i;
  end
  rev_regs_top #(.STEP_CYC0(20), .STEP_CYC1(10)) rev_regs_top_i (.clk_i(clk_i),
    .nrst_i(nrst_i), .ce_i(ce), .chan_hw_enable_pin_i(pins), .fuse_ch1_code_i(5'h0A),
    .fuse_ch2_code_i(3'h5), .fuse_ch3_code_i(3'h2), .fuse_ch4_code_i(5'h06),
    .lnk_clk_i(lnk_clk_i), .lnk_req_i(req), .lnk_we_i(we), .lnk_addr_i(addr),
    .lnk_wdata_i(wdata), .lnk_busy_o(busy), .lnk_done_o(done), .lnk_rdata_o(rdata),
    .chan_run_o(run), .ch1_code_o(c1), .ch2_code_o(c2), .ch3_code_o(c3), .ch4_code_o(c4),
    .ch1_mv_o(mv1), .ch2_mv_o(mv2), .ch3_mv_o(mv3), .ch4_mv_o(mv4));
  rev_host_model rev_host_model_i (.lnk_clk_i(lnk_clk_i), .lnk_busy_i(busy),
    .lnk_done_i(done), .lnk_rdata_i(rdata), .lnk_req_o(req), .lnk_we_o(we),
    .lnk_addr_o(addr), .lnk_wdata_o(wdata));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    rev_host_model_i.xfer(1'b1, a, d, 0, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rev_host_model_i.xfer(1'b0, a, 8'h00, 2, q);
    chk(q, e);
  endtask
  task automatic clks(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic do_reset;
    nrst_i = 1'b0;
    clks(20);
    nrst_i = 1'b1;
    repeat (6) @(posedge lnk_clk_i);
  endtask
  task automatic ramp(input logic [7:0] s, input logic [7:0] a, input logic [7:0] v,
                      input int n);
    wr(ADDR_SCALE, s);
    rd(ADDR_SCALE, s);
    wr(a, v);
    clks(5);
    chk((a == ADDR_CH1_VOLTAGE_CODE ? c1 : c4) != v[4:0], 1'b1);
    clks(n);
    chk(a == ADDR_CH1_VOLTAGE_CODE ? c1 : c4, v[4:0]);
  endtask
  task automatic finish_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // about 10k core cycles of tests; five times that is a hang
  initial begin
    #200000;
    fails++;
    finish_test();
  end
  initial begin
    do_reset();
    rd(ADDR_ENABLE, 8'h1F);
    rd(ADDR_SCALE, 8'h00);
    rd(ADDR_CH1_VOLTAGE_CODE, 8'h0A);
    rd(ADDR_CH2_CH3_VOLTAGE_CODE, 8'h25);
    rd(ADDR_CH4_VOLTAGE_CODE, 8'h06);
    rd(8'h00, 8'h00);
    rd(8'h06, 8'h00);
    chk(run, 5'h1F);
    $display("test reset values done");
    wr(ADDR_ENABLE, 8'hF5);
    chk(q, 8'h1F);
    rd(ADDR_ENABLE, 8'hF5);
    clks(3);
    chk(run, 5'h15);
    pins = 5'h17;
    clks(8);
    rd(ADDR_ENABLE, 8'hFD);
    wr(ADDR_ENABLE, 8'h00);
    rd(ADDR_ENABLE, 8'h08);
    chk(run, 5'h00);
    clks(1);
    pins = 5'h1F;
    clks(8);
    chk(run, 5'h08);
    wr(ADDR_ENABLE, 8'h1F);
    ce = 1'b0;
    pins = 5'h1E;
    clks(8);
    chk(run, 5'h1F);
    ce = 1'b1;
    clks(8);
    chk(run, 5'h1E);
    pins = 5'h1F;
    clks(8);
    rd(ADDR_ENABLE, 8'h1F);
    $display("test channel enable done");
    for (int i = 0; i < 13; i++) begin
      wr(ta[i], td[i]);
      clks(4);
      chk(ta[i] == ADDR_CH1_VOLTAGE_CODE ? mv1 : ta[i] == ADDR_CH4_VOLTAGE_CODE ? mv4 : mv2, te[i]);
      rd(ta[i], td[i]);
    end
    chk(mv3, 13'h708);
    chk(c2, 3'h1);
    $display("test voltage codes done");
    ramp(8'h04, ADDR_CH1_VOLTAGE_CODE, 8'h06, 80);
    ramp(8'h05, ADDR_CH1_VOLTAGE_CODE, 8'h03, 50);
    ramp(8'h06, ADDR_CH1_VOLTAGE_CODE, 8'h04, 4000);
    ramp(8'h70, ADDR_CH4_VOLTAGE_CODE, 8'h1D, 4000);
    ramp(8'h40, ADDR_CH4_VOLTAGE_CODE, 8'h1A, 80);
    $display("test scaling done");
    do_reset();
    rd(ADDR_ENABLE, 8'h1F);
    rd(ADDR_SCALE, 8'h00);
    rd(ADDR_CH4_VOLTAGE_CODE, 8'h06);
    $display("test second reset done");
    finish_test();
  end
endmodule
`default_nettype wire
